// *** dcr_pkg.sv ***
// Package of constants and types for the driver conductance and timer mode registers
`default_nettype none

package dcr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DCR_OFS_N_COND  = 8'h27;
  localparam logic [7:0] DCR_OFS_P_IDLE  = 8'h28;
  localparam logic [7:0] DCR_OFS_P_MOD   = 8'h29;
  localparam logic [7:0] DCR_OFS_TMODE   = 8'h2A;
  localparam logic [7:0] DCR_OFS_CTRL    = 8'h3D;
  localparam logic [7:0] DCR_OFS_STATUS  = 8'h3E;
  localparam logic [7:0] DCR_OFS_MASK    = 8'h3F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DCR_RST_N_COND  = 8'h88;
  localparam logic [5:0] DCR_RST_P_IDLE  = 6'h20;
  localparam logic [5:0] DCR_RST_P_MOD   = 6'h20;
  localparam logic [7:0] DCR_RST_TMODE   = 8'h00;
  localparam logic [3:0] DCR_RST_CTRL    = 4'h0;
  localparam logic [7:0] DCR_ZERO8       = 8'h00;
  localparam logic [15:0] DCR_ZERO16     = 16'h0000;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int DCR_N_W          = 4;
  localparam int DCR_P_W          = 6;
  localparam int DCR_N_IDLE_LSB   = 4;
  localparam int DCR_TM_AUTO_BIT  = 7;
  localparam int DCR_TM_GATE_LSB  = 5;
  localparam int DCR_TM_RLD_BIT   = 4;
  localparam int DCR_PRE_HI_W     = 4;
  localparam int DCR_PRE_LO_W     = 8;
  localparam int DCR_PRE_W        = 12;
  localparam int DCR_RELOAD_W     = 16;
  // Control register bits
  localparam int DCR_CTRL_DRV_A   = 0;
  localparam int DCR_CTRL_DRV_B   = 1;
  localparam int DCR_CTRL_FULLASK = 2;
  localparam int DCR_CTRL_PDOWN   = 3;
  localparam int DCR_CTRL_START   = 4;
  localparam int DCR_CTRL_STOP    = 5;
  // Status and mask bits
  localparam int DCR_STAT_EVT     = 0;
  localparam int DCR_STAT_RUN     = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCR_GATE_NONE   = 2'b00,
    DCR_GATE_SERIAL = 2'b01,
    DCR_GATE_AUX    = 2'b10,
    DCR_GATE_UNDEF  = 2'b11
  } dcr_gate_t;

  typedef enum logic [0:0] {
    DCR_TMR_IDLE = 1'b0,
    DCR_TMR_RUN  = 1'b1
  } dcr_tmr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dcr_bus_req_t;

  typedef struct packed {
    logic mod_active;
    logic tx_end;
  } dcr_tx_stat_t;

  typedef struct packed {
    logic [DCR_N_W-1:0] n_code;
    logic [DCR_P_W-1:0] p_code;
  } dcr_drive_t;

  typedef struct packed {
    logic [7:0]              n_cond;
    logic [DCR_P_W-1:0]      p_idle;
    logic [DCR_P_W-1:0]      p_mod;
    logic [7:0]              tmode;
    logic [3:0]              ctrl;
    logic                    evt_flag;
    logic                    mask_evt;
    dcr_tmr_state_t          tmr_state;
    logic [DCR_RELOAD_W-1:0] tmr_cnt;
    logic [7:0]              rdata;
    dcr_drive_t              drive;
  } dcr_state_t;

endpackage

`default_nettype wire

// *** dcr_cond_sel.sv ***
// Conductance code selector for one output driver
`default_nettype none

module dcr_cond_sel
  import dcr_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic [W-1:0] idle_code,
  input  wire logic [W-1:0] mod_code,
  input  wire logic         mod_active,
  input  wire logic         mod_ignore,
  input  wire logic         drv_on,
  input  wire logic         pdown,
  output logic      [W-1:0] code
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] MSB  = {1'b1, {(W-1){1'b0}}};

  logic [W-1:0] picked;

  // Idle or modulation code, gated by driver enable; code stays binary weighted
  always_comb begin
    if (!drv_on) begin
      picked = ZERO;
    end else if (mod_active) begin
      picked = mod_ignore ? ZERO : mod_code;
    end else begin
      picked = idle_code;
    end
    code = pdown ? (picked | MSB) : picked;
  end

endmodule

`default_nettype wire

// *** dcr_prescaler.sv ***
// Timer prescaler that divides carrier ticks by prescale plus one
`default_nettype none

module dcr_prescaler
  import dcr_pkg::*;
#(
  parameter int W = DCR_PRE_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         restart,
  input  wire logic         carrier_tick,
  input  wire logic [W-1:0] prescale,
  output logic              tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt;
  } dcr_pre_state_t;

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  dcr_pre_state_t st_reg;
  dcr_pre_state_t st_next;

  // One tick every prescale+1 carrier periods
  assign tick = carrier_tick && (st_reg.cnt == prescale) && !restart;

  // Next count
  always_comb begin
    st_next = st_reg;
    if (restart) begin
      st_next.cnt = '0;
    end else if (carrier_tick) begin
      st_next.cnt = (st_reg.cnt == prescale) ? '0 : st_reg.cnt + ONE;
    end
  end

  // Count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// *** dcr_regs.sv ***
// Driver conductance and timer mode register bank with timer core
//
// The implementer's own choice: strobed register access.
`default_nettype none

module dcr_regs
  import dcr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire dcr_bus_req_t              bus_req,
  output logic      [7:0]                rdata,
  input  wire dcr_tx_stat_t              tx_stat,
  input  wire logic                      carrier_tick,
  input  wire logic [DCR_PRE_LO_W-1:0]   prescaler_lower,
  input  wire logic [DCR_RELOAD_W-1:0]   reload_value,
  input  wire logic                      card_serial_in,
  input  wire logic                      aux_pin_one,
  output dcr_drive_t                     drive,
  output logic                           antenna_out_a_en,
  output logic                           antenna_out_b_en,
  output logic                           timer_event_flag,
  output logic                           timer_running,
  output logic                           irq
);

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  localparam logic [DCR_RELOAD_W-1:0] CNT_ONE = 16'h0001;

  dcr_state_t st_reg;
  dcr_state_t st_next;

  logic                     wr_n;
  logic                     wr_pi;
  logic                     wr_pm;
  logic                     wr_tm;
  logic                     wr_ctrl;
  logic                     wr_mask;
  logic                     rd_stat;
  logic                     start_wr;
  logic                     stop_wr;
  logic                     auto_start;
  logic                     tmr_start;
  logic                     gate_open;
  logic                     tick;
  logic                     drv_on;
  logic                     evt_set;
  logic [DCR_PRE_W-1:0]     prescale;
  logic [DCR_N_W-1:0]       n_code;
  logic [DCR_P_W-1:0]       p_code;
  dcr_gate_t                gate_sel;

  // Write strobes per register
  assign wr_n    = bus_req.wr && (bus_req.addr == DCR_OFS_N_COND);
  assign wr_pi   = bus_req.wr && (bus_req.addr == DCR_OFS_P_IDLE);
  assign wr_pm   = bus_req.wr && (bus_req.addr == DCR_OFS_P_MOD);
  assign wr_tm   = bus_req.wr && (bus_req.addr == DCR_OFS_TMODE);
  assign wr_ctrl = bus_req.wr && (bus_req.addr == DCR_OFS_CTRL);
  assign wr_mask = bus_req.wr && (bus_req.addr == DCR_OFS_MASK);
  assign rd_stat = bus_req.rd && (bus_req.addr == DCR_OFS_STATUS);

  // Self-clearing timer commands
  assign start_wr = wr_ctrl && bus_req.wdata[DCR_CTRL_START];
  assign stop_wr  = wr_ctrl && bus_req.wdata[DCR_CTRL_STOP];

  // ----------------------------------------------------------------
  // Timer control terms
  // ----------------------------------------------------------------
  // Protocol start only while auto mode is set
  assign auto_start = tx_stat.tx_end && st_reg.tmode[DCR_TM_AUTO_BIT];
  assign tmr_start  = auto_start || start_wr;

  // Prescale upper bits from mode bits 3:0, lower bits from the lower register
  assign prescale = {st_reg.tmode[DCR_PRE_HI_W-1:0], prescaler_lower};

  // Gate source decode; the undefined code runs ungated
  assign gate_sel = dcr_gate_t'(st_reg.tmode[DCR_TM_GATE_LSB +: 2]);
  always_comb begin
    case (gate_sel)
      DCR_GATE_NONE:   gate_open = 1'b1;
      DCR_GATE_SERIAL: gate_open = card_serial_in;
      DCR_GATE_AUX:    gate_open = aux_pin_one;
      default:         gate_open = 1'b1;
    endcase
  end

  // Carrier divider
  dcr_prescaler #(
    .W (DCR_PRE_W)
  ) u_pre (
    .clk          (clk),
    .rst          (rst),
    .restart      (tmr_start),
    .carrier_tick (carrier_tick),
    .prescale     (prescale),
    .tick         (tick)
  );

  // ----------------------------------------------------------------
  // Driver code selection
  // ----------------------------------------------------------------
  assign drv_on = st_reg.ctrl[DCR_CTRL_DRV_A] || st_reg.ctrl[DCR_CTRL_DRV_B];

  // N driver: idle and modulation codes from one register
  dcr_cond_sel #(
    .W (DCR_N_W)
  ) u_nsel (
    .idle_code  (st_reg.n_cond[DCR_N_IDLE_LSB +: DCR_N_W]),
    .mod_code   (st_reg.n_cond[DCR_N_W-1:0]),
    .mod_active (tx_stat.mod_active),
    .mod_ignore (1'b0),
    .drv_on     (drv_on),
    .pdown      (st_reg.ctrl[DCR_CTRL_PDOWN]),
    .code       (n_code)
  );

  // P driver: modulation code dropped under full ASK
  dcr_cond_sel #(
    .W (DCR_P_W)
  ) u_psel (
    .idle_code  (st_reg.p_idle),
    .mod_code   (st_reg.p_mod),
    .mod_active (tx_stat.mod_active),
    .mod_ignore (st_reg.ctrl[DCR_CTRL_FULLASK]),
    .drv_on     (drv_on),
    .pdown      (st_reg.ctrl[DCR_CTRL_PDOWN]),
    .code       (p_code)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    evt_set = 1'b0;
    // Register writes; reserved bits are not stored
    if (wr_n) begin
      st_next.n_cond = bus_req.wdata;
    end
    if (wr_pi) begin
      st_next.p_idle = bus_req.wdata[DCR_P_W-1:0];
    end
    if (wr_pm) begin
      st_next.p_mod = bus_req.wdata[DCR_P_W-1:0];
    end
    if (wr_tm) begin
      st_next.tmode = bus_req.wdata;
    end
    if (wr_ctrl) begin
      st_next.ctrl = bus_req.wdata[3:0];
    end
    if (wr_mask) begin
      st_next.mask_evt = bus_req.wdata[DCR_STAT_EVT];
    end
    // Timer state machine
    case (st_reg.tmr_state)
      DCR_TMR_IDLE: begin
        if (tmr_start) begin
          st_next.tmr_state = DCR_TMR_RUN;
          st_next.tmr_cnt   = reload_value;
        end
      end
      DCR_TMR_RUN: begin
        if (stop_wr) begin
          st_next.tmr_state = DCR_TMR_IDLE;
        end else if (tmr_start) begin
          st_next.tmr_cnt = reload_value;
        end else if (tick && gate_open) begin
          if (st_reg.tmr_cnt == DCR_ZERO16) begin
            evt_set = 1'b1;
            if (st_reg.tmode[DCR_TM_RLD_BIT]) begin
              st_next.tmr_cnt = reload_value;
            end else begin
              st_next.tmr_state = DCR_TMR_IDLE;
            end
          end else begin
            st_next.tmr_cnt = st_reg.tmr_cnt - CNT_ONE;
          end
        end
      end
      default: begin
        st_next.tmr_state = DCR_TMR_IDLE;
      end
    endcase
    // Sticky event; a read clears it but a new event wins
    if (rd_stat) begin
      st_next.evt_flag = 1'b0;
    end
    if (evt_set) begin
      st_next.evt_flag = 1'b1;
    end
    // Read data one cycle after the strobe
    st_next.rdata = DCR_ZERO8;
    if (bus_req.rd) begin
      case (bus_req.addr)
        DCR_OFS_N_COND: st_next.rdata = st_reg.n_cond;
        DCR_OFS_P_IDLE: st_next.rdata = {2'b00, st_reg.p_idle};
        DCR_OFS_P_MOD:  st_next.rdata = {2'b00, st_reg.p_mod};
        DCR_OFS_TMODE:  st_next.rdata = st_reg.tmode;
        DCR_OFS_CTRL:   st_next.rdata = {4'h0, st_reg.ctrl};
        DCR_OFS_STATUS: st_next.rdata = {6'h00, st_reg.tmr_state == DCR_TMR_RUN,
                                         st_reg.evt_flag};
        DCR_OFS_MASK:   st_next.rdata = {7'h00, st_reg.mask_evt};
        default:        st_next.rdata = DCR_ZERO8;
      endcase
    end
    // Driver codes refreshed on every clock
    st_next.drive.n_code = n_code;
    st_next.drive.p_code = p_code;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg.n_cond    <= DCR_RST_N_COND;
      st_reg.p_idle    <= DCR_RST_P_IDLE;
      st_reg.p_mod     <= DCR_RST_P_MOD;
      st_reg.tmode     <= DCR_RST_TMODE;
      st_reg.ctrl      <= DCR_RST_CTRL;
      st_reg.evt_flag  <= 1'b0;
      st_reg.mask_evt  <= 1'b0;
      st_reg.tmr_state <= DCR_TMR_IDLE;
      st_reg.tmr_cnt   <= DCR_ZERO16;
      st_reg.rdata     <= DCR_ZERO8;
      st_reg.drive     <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata            = st_reg.rdata;
  assign drive            = st_reg.drive;
  assign antenna_out_a_en = st_reg.ctrl[DCR_CTRL_DRV_A];
  assign antenna_out_b_en = st_reg.ctrl[DCR_CTRL_DRV_B];
  assign timer_event_flag = st_reg.evt_flag;
  assign timer_running    = (st_reg.tmr_state == DCR_TMR_RUN);
  assign irq              = st_reg.evt_flag && st_reg.mask_evt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_n_write_read: assert property (@(posedge clk) disable iff (rst)
    wr_n ##1 (bus_req.rd && bus_req.addr == DCR_OFS_N_COND && !bus_req.wr)
      |=> rdata == $past(bus_req.wdata, 2))
    else $error("n conductance readback wrong");

  a_p_rsv_zero: assert property (@(posedge clk) disable iff (rst)
    bus_req.rd && (bus_req.addr == DCR_OFS_P_IDLE || bus_req.addr == DCR_OFS_P_MOD)
      |=> rdata[7:6] == 2'b00)
    else $error("reserved p bits not zero");

  a_pdown_msb: assert property (@(posedge clk) disable iff (rst)
    st_reg.ctrl[DCR_CTRL_PDOWN] |=> drive.n_code[DCR_N_W-1] && drive.p_code[DCR_P_W-1])
    else $error("power-down msb not forced");

  a_drv_off_zero: assert property (@(posedge clk) disable iff (rst)
    !drv_on && !st_reg.ctrl[DCR_CTRL_PDOWN] |=> drive == '0)
    else $error("codes applied with drivers off");

  a_idle_select: assert property (@(posedge clk) disable iff (rst)
    drv_on && !tx_stat.mod_active && !st_reg.ctrl[DCR_CTRL_PDOWN]
      |=> drive.n_code == $past(st_reg.n_cond[DCR_N_IDLE_LSB +: DCR_N_W])
       && drive.p_code == $past(st_reg.p_idle))
    else $error("idle codes not selected");

  a_mod_select: assert property (@(posedge clk) disable iff (rst)
    drv_on && tx_stat.mod_active && !st_reg.ctrl[DCR_CTRL_PDOWN]
      |=> drive.n_code == $past(st_reg.n_cond[DCR_N_W-1:0])
       && drive.p_code == ($past(st_reg.ctrl[DCR_CTRL_FULLASK]) ? '0 : $past(st_reg.p_mod)))
    else $error("modulation codes not selected");

  a_auto_start: assert property (@(posedge clk) disable iff (rst)
    tx_stat.tx_end && st_reg.tmode[DCR_TM_AUTO_BIT] && !stop_wr |=> timer_running)
    else $error("auto start missed");

  a_no_auto: assert property (@(posedge clk) disable iff (rst)
    tx_stat.tx_end && !st_reg.tmode[DCR_TM_AUTO_BIT] && !start_wr && !timer_running
      |=> !timer_running)
    else $error("timer started without auto");

  a_zero_stop: assert property (@(posedge clk) disable iff (rst)
    timer_running && tick && gate_open && !tmr_start && !stop_wr
      && st_reg.tmr_cnt == DCR_ZERO16 && !st_reg.tmode[DCR_TM_RLD_BIT]
      |=> !timer_running && timer_event_flag)
    else $error("zero without reload misbehaved");

  a_zero_reload: assert property (@(posedge clk) disable iff (rst)
    timer_running && tick && gate_open && !tmr_start && !stop_wr
      && st_reg.tmr_cnt == DCR_ZERO16 && st_reg.tmode[DCR_TM_RLD_BIT]
      |=> timer_running && st_reg.tmr_cnt == $past(reload_value))
    else $error("reload at zero missed");

  a_gate_hold: assert property (@(posedge clk) disable iff (rst)
    timer_running && gate_sel == DCR_GATE_SERIAL && !card_serial_in && !tmr_start && !stop_wr
      |=> $stable(st_reg.tmr_cnt))
    else $error("gated timer counted");

  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    evt_set |=> timer_event_flag)
    else $error("timer event lost");

endmodule

`default_nettype wire

// *** tb_dcr_regs.sv ***
// Self-checking testbench for the driver conductance and timer mode register bank
`default_nettype none

module tb_dcr_regs
  import dcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                    clk;
  logic                    rst;
  dcr_bus_req_t            bus;
  logic [7:0]              rdata;
  dcr_tx_stat_t            tx;
  logic                    carrier_tick;
  logic [DCR_PRE_LO_W-1:0] pre_lo;
  logic [DCR_RELOAD_W-1:0] reload;
  logic                    serial_in;
  logic                    aux_in;
  dcr_drive_t              drive;
  logic                    out_a_en;
  logic                    out_b_en;
  logic                    evt_flag;
  logic                    running;
  logic                    irq;
  int                      num_errors;
  int                      samples_checked;
  logic [3:0]              ctrl_v;

  dcr_regs dut (
    .clk              (clk),
    .rst              (rst),
    .bus_req          (bus),
    .rdata            (rdata),
    .tx_stat          (tx),
    .carrier_tick     (carrier_tick),
    .prescaler_lower  (pre_lo),
    .reload_value     (reload),
    .card_serial_in   (serial_in),
    .aux_pin_one      (aux_in),
    .drive            (drive),
    .antenna_out_a_en (out_a_en),
    .antenna_out_b_en (out_b_en),
    .timer_event_flag (evt_flag),
    .timer_running    (running),
    .irq              (irq)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Carrier ticks on every other clock, so the divider also sees idle cycles
  always @(posedge clk) begin
    carrier_tick <= rst ? 1'b0 : ~carrier_tick;
  end

  // ----------------------------------------------------------------
  // Compare, bus and timer helpers
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic chk_drive(input dcr_drive_t got, input dcr_drive_t exp);
    chk8({4'h0, got.n_code}, {4'h0, exp.n_code}, "n code");
    chk8({2'b00, got.p_code}, {2'b00, exp.p_code}, "p code");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // Write then read with no gap between strobes; read data must drop after one cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
    bus.rd    <= 1'b1;
    @(posedge clk);
    bus.rd    <= 1'b0;
    #1 q = rdata;
    @(posedge clk);
    #1 chk8(rdata, 8'h00, "read data held");
  endtask

  task automatic pulse_end();
    @(posedge clk);
    tx.tx_end <= 1'b1;
    @(posedge clk);
    tx.tx_end <= 1'b0;
  endtask

  // Bounded wait for the sticky timer event
  task automatic wait_flag(output int n);
    n = 0;
    while (evt_flag !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // Expected driver codes from register contents, control bits and modulation
  function automatic dcr_drive_t exp_drive(logic [7:0] n, logic [5:0] pi, logic [5:0] pm,
                                           logic [3:0] c, logic m);
    dcr_drive_t e;
    logic       on;
    on       = c[0] | c[1];
    e.n_code = on ? (m ? n[3:0] : n[7:4]) : 4'h0;
    e.p_code = on ? (m ? (c[2] ? 6'h00 : pm) : pi) : 6'h00;
    if (c[3]) begin
      e.n_code[3] = 1'b1;
      e.p_code[5] = 1'b1;
    end
    return e;
  endfunction

  task automatic test_done();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(40000 * 5);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [5:0] pi;
    logic [5:0] pm;
    logic [3:0] c;
    logic       m;
    int         cnt;
    int         p;
    logic [7:0] rst_tab [4];
    logic [7:0] tms [4];
    logic [7:0] los [4];
    logic [7:0] rls [4];
    rst_tab = '{8'h88, 8'h20, 8'h20, 8'h00};
    tms = '{8'h80, 8'h01, 8'h20, 8'h40};
    los = '{8'h02, 8'h00, 8'h01, 8'h01};
    rls = '{8'h03, 8'h01, 8'h02, 8'h02};
    clk = 1'b0;
    rst = 1'b1;
    bus = '0;
    tx = '0;
    pre_lo = '0;
    reload = '0;
    serial_in = 1'b0;
    aux_in = 1'b0;
    ctrl_v = 4'h0;
    num_errors = 0;
    samples_checked = 0;
    d = 8'($urandom(32'h4844E6F6));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values of the four conductance and mode registers
    for (int i = 0; i < 4; i++) begin
      rd(8'h27 + 8'(i), q);
      chk8(q, rst_tab[i], "reset value");
    end
    // Random write and read back, reserved bits masked
    for (int i = 0; i < 24; i++) begin
      a = 8'h27 + 8'($urandom_range(3));
      d = 8'($urandom);
      wr_rd(a, d, q);
      chk8(q, (a == 8'h28 || a == 8'h29) ? (d & 8'h3F) : d, "readback");
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, q);
    chk8(q, 8'h00, "unmapped read");
    // Random driver configurations
    for (int i = 0; i < 40; i++) begin
      d = 8'($urandom);
      pi = 6'($urandom);
      pm = (i % 5 == 0) ? 6'h3F : 6'($urandom);
      c = 4'($urandom);
      m = 1'($urandom);
      wr(DCR_OFS_N_COND, d);
      wr(DCR_OFS_P_IDLE, {2'b11, pi});
      wr(DCR_OFS_P_MOD, {2'b11, pm});
      wr(DCR_OFS_CTRL, {4'h0, c});
      tx.mod_active <= m;
      repeat (3) @(posedge clk);
      #1 chk_drive(drive, exp_drive(d, pi, pm, c, m));
      chk1(out_a_en, c[0], "driver a enable");
      chk1(out_b_en, c[1], "driver b enable");
    end
    tx.mod_active <= 1'b0;
    ctrl_v = 4'h1;
    wr(DCR_OFS_CTRL, {4'h0, ctrl_v});
    // One-shot timer runs, then gated runs with the gate held closed first
    for (int i = 0; i < 4; i++) begin
      wr(DCR_OFS_TMODE, tms[i]);
      pre_lo <= los[i];
      reload <= 16'(rls[i]);
      pulse_end();
      if (i > 0) begin
        @(posedge clk);
        #1 chk1(running, 1'b0, "protocol start ignored");
        wr(DCR_OFS_CTRL, {4'h1, ctrl_v});
      end
      @(posedge clk);
      #1 chk1(running, 1'b1, "timer started");
      if (i > 1) begin
        repeat (40) @(posedge clk);
        #1 chk1(evt_flag, 1'b0, "gate closed");
        serial_in <= (i == 2);
        aux_in <= (i == 3);
      end
      wait_flag(cnt);
      // Two clocks per carrier tick
      p = 2 * (int'({tms[i][3:0], los[i]}) + 1);
      if (i < 2) chk1(cnt >= rls[i] * p - 4 && cnt <= (rls[i] + 1) * p + 4, 1'b1, "period");
      chk1(evt_flag, 1'b1, "timer event");
      @(posedge clk);
      #1 chk1(running, 1'b0, "stop at zero");
      chk1(irq, 1'b0, "masked irq");
      wr(DCR_OFS_MASK, 8'h01);
      @(posedge clk);
      #1 chk1(irq, 1'b1, "unmasked irq");
      rd(DCR_OFS_STATUS, q);
      chk8(q, 8'h01, "status");
      @(posedge clk);
      #1 chk1(evt_flag, 1'b0, "flag cleared");
      chk1(irq, 1'b0, "irq cleared");
      wr(DCR_OFS_MASK, 8'h00);
      serial_in <= 1'b0;
      aux_in <= 1'b0;
    end
    // Reload mode keeps running after reaching zero until stopped; gate code 11 runs ungated
    wr(DCR_OFS_TMODE, 8'h70);
    wr(DCR_OFS_CTRL, {4'h1, ctrl_v});
    wait_flag(cnt);
    chk1(evt_flag, 1'b1, "reload event");
    repeat (2) @(posedge clk);
    #1 chk1(running, 1'b1, "reload keeps running");
    rd(DCR_OFS_STATUS, q);
    chk8(q, 8'h03, "status while running");
    wr(DCR_OFS_CTRL, {4'h2, ctrl_v});
    @(posedge clk);
    #1 chk1(running, 1'b0, "stopped");
    test_done();
  end

endmodule

`default_nettype wire
